// file: rtl/sgc_global_ctrl.sv
// Global identity and control registers of the five-port switch
//
// How it works
// - The run bit lets the switch forward while set, halts it while clear, and resets set.
// - Global control 0 bit 7 picks the alternative collision back-off when set and resets clear.
// - Global control 0 bit 6 resets every state machine and the data path but no configuration.
// - While soft reset is on, incoming packets are refused; configuration registers keep their values but the flush bits 5 and 4 clear.
// - Writing one to bit 5 starts a dynamic table flush, and the bit clears itself.
// - The dynamic flush only removes entries of ports with learning off, so software turns it off first.
// - Writing one to bit 4 starts a static table flush of matching entries, and the bit clears itself.
// - A static entry matches when unicast with exactly one forwarding port whose learning is off.
// - With pause drop select set, frames with type 0x8808 or the pause group address are dropped.
// - With pause drop select clear, only frames classed as flow control are dropped; it resets clear.
// - With link-change aging on, a port going from link to no link starts a fast age under 800 us.
// - After a fast age cycle, aging returns to its normal 300 s period.
// - With link-change aging on, losing any port's link ages out every learned address.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
`include "sgc_params.svh"

module sgc_global_ctrl #(
    parameter int NUM_PORTS = 5,
    parameter int STATIC_ENTRIES = 32,
    parameter logic [7:0] FAMILY_IDENTITY = 8'h5A,  // Arbitrary value
    parameter logic [3:0] PART_ID = 4'h3,     // Arbitrary value
    parameter logic [2:0] REVISION = 3'h1,    // Arbitrary value
    parameter logic [36:0] FAST_AGE_CYC = 37'(`SGC_FAST_AGE_CYC),
    parameter logic [36:0] AGE_PERIOD_CYC = 37'(`SGC_AGE_PERIOD_CYC)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register bus
    input wire sgc_pkg::sgc_wb_req_t wb_req,
    output sgc_pkg::sgc_wb_rsp_t wb_rsp,
    // Port status
    input wire logic [NUM_PORTS-1:0] link_up,
    input wire logic [NUM_PORTS-1:0] learn_disabled,
    // Frame classification
    input wire sgc_pkg::sgc_frame_t frame,
    output logic frame_drop,
    output logic frame_drop_valid,
    // Switch control
    output logic switch_run,
    output logic rx_accept,
    output logic backoff_alt_sel,
    output logic soft_reset_active,
    output logic pause_drop_select,
    // Dynamic table flush
    output logic dyn_flush_req,
    output logic [NUM_PORTS-1:0] dyn_flush_ports,
    // Static table walk
    output logic [$clog2(STATIC_ENTRIES)-1:0] static_index,
    input wire sgc_pkg::sgc_static_entry_t static_entry,
    output logic static_clear,
    output logic [$clog2(STATIC_ENTRIES)-1:0] static_clear_index,
    // Aging
    output logic fast_age_active,
    output logic age_tick,
    output logic age_all
);
    import sgc_pkg::*;

    localparam int IW = $clog2(STATIC_ENTRIES);
    localparam logic [IW-1:0] LAST_INDEX = IW'(STATIC_ENTRIES - 1);

    logic run_reg;
    logic backoff_reg;
    logic soft_rst_reg;
    logic dyn_flush_reg;
    logic stat_flush_reg;
    logic pause_sel_reg;
    logic link_age_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [7:0] rdat_next;
    logic [NUM_PORTS-1:0] link_prev_reg;
    logic link_fell;
    logic wr_stb;
    logic [5:0] reg_idx;
    logic [7:0] wbyte;
    sgc_walk_t walk_reg;
    logic [IW-1:0] idx_reg;
    logic [36:0] age_cnt_reg;
    logic fast_reg;

    // Static entry qualifies for flushing
    function automatic logic static_match(input sgc_static_entry_t e, input logic [NUM_PORTS-1:0] ld);
        logic hit;
        hit = e.valid && !e.mac[`SGC_GROUP_BIT] && $onehot(e.fwd_ports);
        return hit && ((e.fwd_ports & ld) != '0);
    endfunction

    // Write strobe aimed at one register index
    function automatic logic reg_write(input logic stb, input logic [5:0] idx, input logic [1:0] target);
        logic hit;
        hit = stb && idx == {4'h0, target};
        return hit;
    endfunction

    // Bus decode
    assign reg_idx = wb_req.adr[7:2];
    assign wbyte = wb_req.dat[7:0];
    assign wr_stb = wb_req.cyc && wb_req.stb && wb_req.we && !ack_reg && wb_req.sel[0];
    assign link_fell = |(link_prev_reg & ~link_up);

    // Read data mux
    always_comb begin
        rdat_next = 8'h00;
        // Indices past the last register read zero
        if (reg_idx <= `SGC_IDX_LAST) begin
            unique case (reg_idx[1:0])
                `SGC_IDX_FAMILY: rdat_next = FAMILY_IDENTITY;
                `SGC_IDX_CHIP_RUN: rdat_next = {PART_ID, REVISION, run_reg};
                `SGC_IDX_GCTL0: begin
                    rdat_next = `SGC_GCTL0_RSVD;
                    rdat_next[`SGC_BIT_BACKOFF] = backoff_reg;
                    rdat_next[`SGC_BIT_SOFT_RST] = soft_rst_reg;
                    rdat_next[`SGC_BIT_DYN_FLUSH] = dyn_flush_reg;
                    rdat_next[`SGC_BIT_STAT_FLUSH] = stat_flush_reg;
                    rdat_next[`SGC_BIT_PAUSE_SEL] = pause_sel_reg;
                    rdat_next[`SGC_BIT_LINK_AGE] = link_age_reg;
                end
                `SGC_IDX_GCTL1: rdat_next = `SGC_GCTL1_RSVD;
            endcase
        end
    end

    // Bus answer, one wait state
    // Unmapped indices still answer so the master never hangs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h00000000;
        end else begin
            ack_reg <= wb_req.cyc && wb_req.stb && !ack_reg;
            rdat_reg <= {24'h000000, rdat_next};
        end
    end

    // Configuration bits; soft reset leaves these alone
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_reg <= `SGC_RST_RUN;
            backoff_reg <= 1'b0;
            soft_rst_reg <= 1'b0;
            pause_sel_reg <= 1'b0;
            link_age_reg <= 1'b0;
        end else if (reg_write(wr_stb, reg_idx, `SGC_IDX_CHIP_RUN)) begin
            run_reg <= wbyte[`SGC_BIT_RUN];
        end else if (reg_write(wr_stb, reg_idx, `SGC_IDX_GCTL0)) begin
            backoff_reg <= wbyte[`SGC_BIT_BACKOFF];
            soft_rst_reg <= wbyte[`SGC_BIT_SOFT_RST];
            pause_sel_reg <= wbyte[`SGC_BIT_PAUSE_SEL];
            // Link-change aging enable
            link_age_reg <= wbyte[`SGC_BIT_LINK_AGE];
        end
    end

    // Dynamic flush trigger, self clearing
    // A trigger written while soft reset is on is lost
    always_ff @(posedge clk) begin
        if (!rst_b || soft_rst_reg) begin
            dyn_flush_reg <= 1'b0;
            dyn_flush_req <= 1'b0;
            dyn_flush_ports <= '0;
        end else begin
            dyn_flush_reg <= reg_write(wr_stb, reg_idx, `SGC_IDX_GCTL0) && wbyte[`SGC_BIT_DYN_FLUSH];
            dyn_flush_req <= dyn_flush_reg;
            if (dyn_flush_reg) begin
                dyn_flush_ports <= learn_disabled;
            end
        end
    end

    // Static flush walker over the table
    // One index per cycle; a trigger during a walk is ignored
    always_ff @(posedge clk) begin
        if (!rst_b || soft_rst_reg) begin
            walk_reg <= SGC_WALK_IDLE;
            idx_reg <= '0;
            stat_flush_reg <= 1'b0;
            static_clear <= 1'b0;
            static_clear_index <= '0;
        end else begin
            static_clear <= 1'b0;
            unique case (walk_reg)
                SGC_WALK_IDLE: begin
                    idx_reg <= '0;
                    if (reg_write(wr_stb, reg_idx, `SGC_IDX_GCTL0) && wbyte[`SGC_BIT_STAT_FLUSH]) begin
                        stat_flush_reg <= 1'b1;
                        walk_reg <= SGC_WALK_RUN;
                    end
                end
                SGC_WALK_RUN: begin
                    if (static_match(static_entry, learn_disabled)) begin
                        static_clear <= 1'b1;
                        static_clear_index <= idx_reg;
                    end
                    if (idx_reg == LAST_INDEX) begin
                        stat_flush_reg <= 1'b0;
                        walk_reg <= SGC_WALK_IDLE;
                    end else begin
                        idx_reg <= idx_reg + IW'(1);
                    end
                end
            endcase
        end
    end

    assign static_index = idx_reg;

    // Link state history for edge detection
    // Cleared at reset so a port already down is not seen as a loss
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            link_prev_reg <= '0;
        end else begin
            link_prev_reg <= link_up;
        end
    end

    // Aging timer, normal or fast period
    always_ff @(posedge clk) begin
        if (!rst_b || soft_rst_reg) begin
            fast_reg <= 1'b0;
            age_cnt_reg <= '0;
            age_tick <= 1'b0;
            age_all <= 1'b0;
        end else begin
            age_tick <= 1'b0;
            age_all <= 1'b0;
            // A new link loss restarts the fast cycle
            if (link_age_reg && link_fell) begin
                fast_reg <= 1'b1;
                age_cnt_reg <= '0;
            end else if (fast_reg && age_cnt_reg >= FAST_AGE_CYC - 37'd1) begin
                age_all <= 1'b1;
                fast_reg <= 1'b0;
                age_cnt_reg <= '0;
            end else if (!fast_reg && age_cnt_reg >= AGE_PERIOD_CYC - 37'd1) begin
                age_tick <= 1'b1;
                age_cnt_reg <= '0;
            end else begin
                age_cnt_reg <= age_cnt_reg + 37'd1;
            end
        end
    end

    // Frame drop decision
    // Verdict follows the header by one cycle
    always_ff @(posedge clk) begin
        if (!rst_b || soft_rst_reg) begin
            frame_drop <= 1'b0;
            frame_drop_valid <= 1'b0;
        end else begin
            frame_drop_valid <= frame.valid;
            if (pause_sel_reg) begin
                frame_drop <= frame.type_len == `SGC_PAUSE_TYPE || frame.dest == `SGC_PAUSE_DA;
            end else begin
                frame_drop <= frame.flow_ctrl;
            end
        end
    end

    // Control outputs from flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            switch_run <= `SGC_RST_RUN;
            rx_accept <= 1'b0;
            backoff_alt_sel <= 1'b0;
            soft_reset_active <= 1'b0;
            pause_drop_select <= 1'b0;
            fast_age_active <= 1'b0;
        end else begin
            switch_run <= run_reg;
            rx_accept <= run_reg && !soft_rst_reg;
            backoff_alt_sel <= backoff_reg;
            soft_reset_active <= soft_rst_reg;
            pause_drop_select <= pause_sel_reg;
            fast_age_active <= fast_reg;
        end
    end

    assign wb_rsp.ack = ack_reg;
    assign wb_rsp.dat = rdat_reg;

endmodule

// file: rtl/sgc_params.svh
// Offsets, field positions, reset values and timing counts of the global control bank
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH

// Register indices; byte address is four times the index
`define SGC_IDX_FAMILY 2'h0
`define SGC_IDX_CHIP_RUN 2'h1
`define SGC_IDX_GCTL0 2'h2
`define SGC_IDX_GCTL1 2'h3
`define SGC_IDX_LAST 6'h03

// Chip identity and run register fields
`define SGC_BIT_RUN 0
`define SGC_RST_RUN 1'b1

// Global control 0 fields
`define SGC_BIT_BACKOFF 7
`define SGC_BIT_SOFT_RST 6
`define SGC_BIT_DYN_FLUSH 5
`define SGC_BIT_STAT_FLUSH 4
`define SGC_BIT_PAUSE_SEL 1
`define SGC_BIT_LINK_AGE 0
`define SGC_GCTL0_RSVD 8'h0C

// Global control 1: only the reserved top bit is held here
`define SGC_GCTL1_RSVD 8'h00

// Pause frame recognition
`define SGC_PAUSE_TYPE 16'h8808
`define SGC_PAUSE_DA 48'h0180C2000001
`define SGC_GROUP_BIT 40

// Timing
`define SGC_CLK_MHZ 250
`define SGC_FAST_AGE_US 800
`define SGC_FAST_AGE_CYC (`SGC_FAST_AGE_US * `SGC_CLK_MHZ)
`define SGC_AGE_PERIOD_S 300
`define SGC_AGE_PERIOD_CYC (64'd300 * 64'd1000000 * 64'd250)

`endif

// file: rtl/sgc_pkg.sv
// Types shared by the global control bank and its bench
package sgc_pkg;

    // Wishbone classic request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sgc_wb_req_t;

    // Wishbone classic answer
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } sgc_wb_rsp_t;

    // Header fields of a received frame
    typedef struct packed {
        logic valid;
        logic [47:0] dest;
        logic [15:0] type_len;
        logic flow_ctrl;
    } sgc_frame_t;

    // One static address table entry
    typedef struct packed {
        logic valid;
        logic [47:0] mac;
        logic [4:0] fwd_ports;
    } sgc_static_entry_t;

    // Static flush walker states
    typedef enum logic {
        SGC_WALK_IDLE,
        SGC_WALK_RUN
    } sgc_walk_t;

endpackage

// file: testbench/sgc_global_ctrl_monitor.sv
// Port-level checks on the global control bank
`timescale 1ns/100ps
module sgc_global_ctrl_mon #(
    parameter int NUM_PORTS = 5,
    parameter int STATIC_ENTRIES = 32
) (
    // Clock, reset and bus
    input wire logic clk,
    input wire logic rst_b,
    input wire sgc_pkg::sgc_wb_req_t wb_req,
    input wire sgc_pkg::sgc_wb_rsp_t wb_rsp,
    // Ports and frames
    input wire logic [NUM_PORTS-1:0] learn_disabled,
    input wire sgc_pkg::sgc_frame_t frame,
    input wire logic frame_drop,
    // Control outputs
    input wire logic switch_run,
    input wire logic rx_accept,
    input wire logic soft_reset_active,
    input wire logic pause_drop_select,
    input wire logic dyn_flush_req,
    input wire logic age_tick,
    input wire logic age_all,
    // Static walk
    input wire logic [$clog2(STATIC_ENTRIES)-1:0] static_index,
    input wire sgc_pkg::sgc_static_entry_t static_entry,
    input wire logic static_clear,
    input wire logic [$clog2(STATIC_ENTRIES)-1:0] static_clear_index
);
    import sgc_pkg::*;
    logic req_new, dyn_wr, pmatch, smatch;
    // Decoded causes
    assign req_new = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    assign dyn_wr = req_new && wb_req.we && wb_req.adr == 8'h08 && wb_req.sel[0] && wb_req.dat[5] && !wb_req.dat[6];
    assign pmatch = frame.type_len == 16'h8808 || frame.dest == 48'h0180C2000001;
    assign smatch = static_entry.valid && !static_entry.mac[40] && $onehot(static_entry.fwd_ports)
        && |(static_entry.fwd_ports & learn_disabled);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_ack_one_wait: assert property (req_new |=> wb_rsp.ack ##1 !wb_rsp.ack) else $error("ack timing wrong");
    a_run_gates_rx: assert property (rx_accept |-> switch_run) else $error("rx while stopped");
    a_soft_blocks_rx: assert property (soft_reset_active |-> !rx_accept) else $error("rx in soft reset");
    a_soft_quiet: assert property (soft_reset_active && $past(soft_reset_active)
        |-> !(dyn_flush_req || static_clear || age_tick || age_all || frame_drop)) else $error("activity in soft reset");
    a_pause_drop: assert property (frame.valid && pmatch
        |=> frame_drop || !pause_drop_select || soft_reset_active) else $error("pause frame kept");
    a_flow_drop: assert property (frame.valid && frame.flow_ctrl
        |=> frame_drop || pause_drop_select || soft_reset_active) else $error("flow frame kept");
    a_plain_kept: assert property (frame.valid && !frame.flow_ctrl && !pmatch |=> !frame_drop) else $error("frame dropped");
    a_dyn_pulse: assert property (dyn_wr && !soft_reset_active
        |-> ##[1:3] dyn_flush_req ##1 !dyn_flush_req) else $error("flush pulse wrong");
    a_static_match: assert property (static_clear
        |-> $past(smatch) && static_clear_index == $past(static_index)) else $error("bad static clear");
endmodule
bind sgc_global_ctrl sgc_global_ctrl_mon #(.NUM_PORTS(NUM_PORTS), .STATIC_ENTRIES(STATIC_ENTRIES)) u_mon (
    .clk(clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp), .learn_disabled(learn_disabled),
    .frame(frame), .frame_drop(frame_drop), .switch_run(switch_run), .rx_accept(rx_accept),
    .soft_reset_active(soft_reset_active), .pause_drop_select(pause_drop_select),
    .dyn_flush_req(dyn_flush_req), .age_tick(age_tick), .age_all(age_all), .static_index(static_index),
    .static_entry(static_entry), .static_clear(static_clear), .static_clear_index(static_clear_index));

// file: testbench/tb_top.sv
// Self-checking bench for the global control bank
`timescale 1ns/100ps
module tb_top;
    import sgc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    sgc_wb_req_t req = '0;
    sgc_wb_rsp_t rsp;
    logic [4:0] link_up = 5'h1F;
    logic [4:0] learn_dis = 5'h00;
    sgc_frame_t frame = '0;
    sgc_static_entry_t tab [8] = '{default: '0};
    logic [2:0] s_idx, c_idx;
    logic drop, drop_v, run, rx_ok, boff, soft_on, psel, dyn_req, s_clr, fast_on, tick, age_all;
    logic [4:0] dyn_ports;
    logic [31:0] rdat;
    logic [2:0] clr_q [$];
    int n_errors = 0;
    int checked = 0;
    int cyc_cnt = 0;
    int n;
    sgc_global_ctrl #(.STATIC_ENTRIES(8), .FAST_AGE_CYC(37'h14), .AGE_PERIOD_CYC(37'h64)) u_dut (
        .clk(clk), .rst_b(rst_b), .wb_req(req), .wb_rsp(rsp), .link_up(link_up), .learn_disabled(learn_dis),
        .frame(frame), .frame_drop(drop), .frame_drop_valid(drop_v), .switch_run(run), .rx_accept(rx_ok),
        .backoff_alt_sel(boff), .soft_reset_active(soft_on), .pause_drop_select(psel), .dyn_flush_req(dyn_req),
        .dyn_flush_ports(dyn_ports), .static_index(s_idx), .static_entry(tab[s_idx]), .static_clear(s_clr),
        .static_clear_index(c_idx), .fast_age_active(fast_on), .age_tick(tick), .age_all(age_all));
    // Clock and hang guard
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        if (s_clr === 1'b1) clr_q.push_back(c_idx);
        cyc_cnt++;
        if (cyc_cnt == 2000) begin
            n_errors++;
            test_done();
        end
    end
    task test_done;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One classic cycle, read data kept in rdat
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h0, d}};
        @(posedge clk);
        while (rsp.ack !== 1'b1) @(posedge clk);
        rdat = rsp.dat;
        req <= '0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(rdat, {24'h0, e});
    endtask
    // One frame, then its drop verdict
    task fr(input logic [47:0] da, input logic [15:0] tl, input logic fc, input logic [1:0] e);
        frame <= '{valid: 1'b1, dest: da, type_len: tl, flow_ctrl: fc};
        @(posedge clk);
        frame.valid <= 1'b0;
        @(posedge clk);
        chk({drop_v, drop}, e);
    endtask
    // Main sequence
    initial begin
        tab[2] = '{1'b1, 48'h020000000002, 5'h01};
        tab[3] = '{1'b1, 48'h010000000003, 5'h01};
        tab[4] = '{1'b1, 48'h020000000004, 5'h05};
        tab[5] = '{1'b1, 48'h020000000005, 5'h02};
        tab[6] = '{1'b1, 48'h020000000006, 5'h04};
        tab[7] = '{1'b0, 48'h020000000007, 5'h01};
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk(run, 1'b1);
        rd(8'h00, 8'h5A);
        rd(8'h04, 8'h33);
        rd(8'h08, 8'h0C);
        rd(8'h0C, 8'h00);
        wb(1'b1, 8'h00, 8'hFF);
        wb(1'b1, 8'h04, 8'h00);
        wb(1'b1, 8'h10, 8'hFF);
        rd(8'h00, 8'h5A);
        rd(8'h04, 8'h32);
        rd(8'h10, 8'h00);
        chk({run, rx_ok}, 2'b00);
        wb(1'b1, 8'h04, 8'h01);
        wb(1'b1, 8'h08, 8'h82);
        rd(8'h08, 8'h8E);
        chk({boff, psel, rx_ok}, 3'b111);
        fr(48'h0A0000000001, 16'h8808, 1'b0, 2'b11);
        fr(48'h0180C2000001, 16'h0800, 1'b0, 2'b11);
        fr(48'h0A0000000001, 16'h0800, 1'b1, 2'b10);
        wb(1'b1, 8'h08, 8'h80);
        fr(48'h0A0000000001, 16'h0800, 1'b1, 2'b11);
        fr(48'h0A0000000001, 16'h8808, 1'b0, 2'b10);
        wb(1'b1, 8'h08, 8'hC0);
        @(posedge clk);
        chk({soft_on, rx_ok, run}, 3'b101);
        fr(48'h0A0000000001, 16'h0800, 1'b1, 2'b00);
        rd(8'h08, 8'hCC);
        rd(8'h04, 8'h33);
        wb(1'b1, 8'h08, 8'h80);
        repeat (2) @(posedge clk);
        chk({soft_on, rx_ok}, 2'b01);
        learn_dis <= 5'h15;
        wb(1'b1, 8'h08, 8'hA0);
        n = 0;
        while (dyn_req !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk({n < 8, dyn_ports}, {1'b1, 5'h15});
        rd(8'h08, 8'h8C);
        wb(1'b1, 8'h08, 8'h90);
        rd(8'h08, 8'h9C);
        repeat (12) @(posedge clk);
        rd(8'h08, 8'h8C);
        chk({clr_q.size() == 2, clr_q[0], clr_q[1]}, {1'b1, 3'h2, 3'h6});
        wb(1'b1, 8'h08, 8'h81);
        link_up <= 5'h17;
        n = 0;
        while (age_all !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk({n >= 18 && n <= 24, fast_on}, 2'b11);
        n = 0;
        @(posedge clk);
        while (tick !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk(n >= 95 && n <= 105, 1'b1);
        test_done();
    end
endmodule
